// ---- logic/sram_pin_pkg.sv ----
// Shared widths, reset values and pin constants for the burst SRAM pin front end
package sram_pin_pkg;

	// ==================================================
	// Geometry
	localparam int ADDR_W  = 19;
	localparam int LANES   = 4;
	localparam int BYTE_W  = 8;
	localparam int LANE_W  = BYTE_W + 1;
	localparam int BURST_W = 2;

	// ==================================================
	// Values after reset
	localparam logic       SEL_RST    = 1'b0;
	localparam logic       WR_RST     = 1'b0;
	localparam logic [1:0] STEP_RST   = 2'h0;
	localparam logic       STRAP_RST  = 1'b1;
	localparam logic       LANE_N_RST = 1'b1;

endpackage

// ---- logic/burst_seq.sv ----
// Burst sequence generator for the low address bits
`timescale 1ns/100ps
module burst_seq #(
	parameter int BURST_W = sram_pin_pkg::BURST_W
) (
	// Mode
	input  wire logic               interleave,
	// Burst position
	input  wire logic [BURST_W-1:0] start_low,
	input  wire logic [BURST_W-1:0] step,
	// Result
	output logic      [BURST_W-1:0] seq_low
);

	// ==================================================
	// Order select
	// Add wraps naturally inside the group, upper bits never touched
	wire [BURST_W-1:0] linear_low     = BURST_W'(start_low + step); // RULE17
	wire [BURST_W-1:0] interleave_low = start_low ^ step;           // RULE17

	assign seq_low = interleave ? interleave_low : linear_low; // RULE16

endmodule

// ---- logic/sram_core.sv ----
// Lane-writable storage array with registered read port and write forwarding
`timescale 1ns/100ps
module sram_core #(
	parameter int ADDR_W = sram_pin_pkg::ADDR_W,
	parameter int LANES  = sram_pin_pkg::LANES,
	parameter int LANE_W = sram_pin_pkg::LANE_W
) (
	// Clock and reset
	input  wire logic                    core_clk,
	input  wire logic                    sys_rst,
	// Write port
	input  wire logic [LANES-1:0]        wr_lane_en,
	input  wire logic [ADDR_W-1:0]       wr_addr,
	input  wire logic [LANES*LANE_W-1:0] wr_data,
	// Read port
	input  wire logic                    rd_en,
	input  wire logic [ADDR_W-1:0]       rd_addr,
	output logic      [LANES*LANE_W-1:0] rd_data
);

	// ==================================================
	// Storage, one array per lane
	wire same_addr = (wr_addr == rd_addr);

	genvar i;
	generate
		for (i = 0; i < LANES; i++) begin : g_lane
			logic [LANE_W-1:0] mem [0:(1<<ADDR_W)-1];
			logic [LANE_W-1:0] rd_lane_reg;
			// Forwarding keeps a read in the same edge as a write coherent
			wire fwd = wr_lane_en[i] & same_addr;

			always_ff @(posedge core_clk) begin
				if (wr_lane_en[i]) begin
					mem[wr_addr] <= wr_data[i*LANE_W +: LANE_W];
				end
			end

			always_ff @(posedge core_clk or posedge sys_rst) begin
				if (sys_rst) begin
					rd_lane_reg <= '0;
				end else if (rd_en) begin
					rd_lane_reg <= fwd ? wr_data[i*LANE_W +: LANE_W] : mem[rd_addr];
				end
			end

			// One register per lane, so no two processes share the read word
			assign rd_data[i*LANE_W +: LANE_W] = rd_lane_reg;
		end
	endgenerate

endmodule

// ---- logic/sram_pin_ctrl.sv ----
// Synchronous control-pin front end of a pipelined burst SRAM
// ==================================================
// Operation
// RULE1 - The address inputs are captured on the rising edge and select one storage location.
// RULE2 - Each active-low lane write select, qualified by the write strobe, writes its data byte and parity bit.
// RULE3 - The controller drives the active-low write strobe low to start a write; high means a read.
// RULE4 - The write strobe and all other synchronous inputs are sampled only on edges with clock qualify low.
// RULE5 - Edges with clock qualify high are ignored completely: no capture, no state change.
// RULE6 - Every synchronous input is registered on the rising clock edge.
// RULE7 - Burst step/load high at a qualified edge advances the internal burst counter.
// RULE8 - Burst step/load low at a qualified edge loads the presented address as a new access.
// RULE9 - The controller loads a fresh address on the first access after a deselected period.
// RULE10 - The device is selected only with select one low, select two high and select three low.
// RULE11 - Output enable acts asynchronously with internal control; low lets the data pins drive.
// RULE12 - Output enable high leaves the data pins undriven so they act as inputs.
// RULE13 - Data pins stay undriven in write data phases, the first clock after deselection and when deselected.
// RULE14 - Clock qualify high does not deselect; it just stretches the previous cycle.
// RULE15 - Read data appear on the pins one qualified edge after the address was taken.
// RULE16 - A static strap picks interleaved order when high and linear order when low.
// RULE17 - The burst counter steps only the two low address bits and wraps in a group of four.
`timescale 1ns/100ps
module sram_pin_ctrl #(
	parameter int ADDR_W  = sram_pin_pkg::ADDR_W,
	parameter int LANES   = sram_pin_pkg::LANES,
	parameter int BYTE_W  = sram_pin_pkg::BYTE_W,
	parameter int LANE_W  = sram_pin_pkg::LANE_W,
	parameter int BURST_W = sram_pin_pkg::BURST_W
) (
	// Clock and reset
	input  wire logic                    core_clk,
	input  wire logic                    sys_rst,
	// Clock qualification
	input  wire logic                    clock_qualify_n,
	// Address and burst control
	input  wire logic [ADDR_W-1:0]       addr,
	input  wire logic                    burst_step_or_load,
	input  wire logic                    burst_order_strap,
	// Selects and strobes
	input  wire logic                    chip_sel_one_n,
	input  wire logic                    chip_sel_two,
	input  wire logic                    chip_sel_three_n,
	input  wire logic                    write_strobe_n,
	input  wire logic                    lane_a_write_sel_n,
	input  wire logic                    lane_b_write_sel_n,
	input  wire logic                    lane_c_write_sel_n,
	input  wire logic                    lane_d_write_sel_n,
	input  wire logic                    out_enable_n,
	// Data pins
	input  wire logic [LANES*BYTE_W-1:0] data_pins_in,
	output logic      [LANES*BYTE_W-1:0] data_pins_out,
	output logic      [LANES*BYTE_W-1:0] data_pins_oe,
	// Parity pins
	input  wire logic [LANES-1:0]        parity_pins_in,
	output logic      [LANES-1:0]        parity_pins_out,
	output logic      [LANES-1:0]        parity_pins_oe
);

	// ==================================================
	// Edge qualification
	// Clock-gating by enable keeps a single clock tree
	wire qual = ~clock_qualify_n; // RULE4 RULE5 RULE14

	// ==================================================
	// Strap synchroniser
	logic strap_meta_reg;
	logic strap_sync_reg;

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			strap_meta_reg <= sram_pin_pkg::STRAP_RST;
			strap_sync_reg <= sram_pin_pkg::STRAP_RST;
		end else begin
			strap_meta_reg <= burst_order_strap;
			strap_sync_reg <= strap_meta_reg;
		end
	end

	// ==================================================
	// Input decode
	wire             load_now  = ~burst_step_or_load;                                    // RULE8
	wire             sel_now   = ~chip_sel_one_n & chip_sel_two & ~chip_sel_three_n;    // RULE10
	wire             write_now = ~write_strobe_n;                                        // RULE3
	wire [LANES-1:0] lane_n_now = {lane_d_write_sel_n, lane_c_write_sel_n,
		lane_b_write_sel_n, lane_a_write_sel_n};                                          // RULE2

	// ==================================================
	// Command stage, taken at the qualified edge
	logic                      s1_sel_reg;
	logic                      s1_wr_reg;
	logic [LANES-1:0]          s1_lane_n_reg;
	logic [ADDR_W-1:BURST_W]   upper_reg;
	logic [BURST_W-1:0]        start_low_reg;
	logic [BURST_W-1:0]        step_reg;

	// A burst step keeps the select and direction of the access it continues
	wire                    s1_sel_next    = load_now ? sel_now : s1_sel_reg;            // RULE7 RULE8
	wire                    s1_wr_next     = load_now ? write_now : s1_wr_reg;           // RULE7 RULE8
	wire [ADDR_W-1:BURST_W] upper_next     = load_now ? addr[ADDR_W-1:BURST_W] : upper_reg; // RULE17
	wire [BURST_W-1:0]      start_low_next = load_now ? addr[BURST_W-1:0] : start_low_reg;  // RULE1
	wire [BURST_W-1:0]      step_next      = load_now ? sram_pin_pkg::STEP_RST
		: BURST_W'(step_reg + 1'b1);                                                     // RULE7

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s1_sel_reg    <= sram_pin_pkg::SEL_RST;
			s1_wr_reg     <= sram_pin_pkg::WR_RST;
			s1_lane_n_reg <= {LANES{sram_pin_pkg::LANE_N_RST}};
			upper_reg     <= '0;
			start_low_reg <= '0;
			step_reg      <= sram_pin_pkg::STEP_RST;
		end else if (qual) begin // RULE6
			s1_sel_reg    <= s1_sel_next;
			s1_wr_reg     <= s1_wr_next;
			s1_lane_n_reg <= lane_n_now;
			upper_reg     <= upper_next;
			start_low_reg <= start_low_next;
			step_reg      <= step_next;
		end
	end

	// ==================================================
	// Burst address
	logic [BURST_W-1:0] burst_low;

	burst_seq #(
		.BURST_W   (BURST_W)
	) u_burst_seq (
		.interleave (strap_sync_reg),
		.start_low  (start_low_reg),
		.step       (step_reg),
		.seq_low    (burst_low)
	);

	wire [ADDR_W-1:0] s1_addr = {upper_reg, burst_low}; // RULE1 RULE17

	// ==================================================
	// Data stage
	logic              s2_sel_reg;
	logic              s2_wr_reg;
	logic [LANES-1:0]  s2_lane_n_reg;
	logic [ADDR_W-1:0] s2_addr_reg;

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s2_sel_reg    <= sram_pin_pkg::SEL_RST;
			s2_wr_reg     <= sram_pin_pkg::WR_RST;
			s2_lane_n_reg <= {LANES{sram_pin_pkg::LANE_N_RST}};
			s2_addr_reg   <= '0;
		end else if (qual) begin // RULE5
			s2_sel_reg    <= s1_sel_reg;
			s2_wr_reg     <= s1_wr_reg;
			s2_lane_n_reg <= s1_lane_n_reg;
			s2_addr_reg   <= s1_addr;
		end
	end

	// ==================================================
	// Storage
	// Write data lands two edges after the command, in the same slot a read
	// would use, so turning the bus round never costs a dead cycle
	wire [LANES-1:0]        wr_lane_en = {LANES{qual & s2_sel_reg & s2_wr_reg}} & ~s2_lane_n_reg; // RULE2
	wire                    rd_en      = qual & s1_sel_reg & ~s1_wr_reg;                          // RULE15
	logic [LANES*LANE_W-1:0] wr_word;
	logic [LANES*LANE_W-1:0] rd_word;

	sram_core #(
		.ADDR_W     (ADDR_W),
		.LANES      (LANES),
		.LANE_W     (LANE_W)
	) u_sram_core (
		.core_clk   (core_clk),
		.sys_rst    (sys_rst),
		.wr_lane_en (wr_lane_en),
		.wr_addr    (s2_addr_reg),
		.wr_data    (wr_word),
		.rd_en      (rd_en),
		.rd_addr    (s1_addr),
		.rd_data    (rd_word)
	);

	// ==================================================
	// Pin direction
	// Output enable stays combinational; it is not sampled by the clock
	wire emerging   = s1_sel_reg & ~s2_sel_reg;                  // RULE13
	wire slot_read  = s2_sel_reg & ~s2_wr_reg;                   // RULE13 RULE15
	wire drive_pins = ~out_enable_n & slot_read & ~emerging;     // RULE11 RULE12 RULE13

	// ==================================================
	// Lane packing
	genvar i;
	generate
		for (i = 0; i < LANES; i++) begin : g_pins
			assign wr_word[i*LANE_W +: LANE_W]     = {parity_pins_in[i], data_pins_in[i*BYTE_W +: BYTE_W]}; // RULE2
			assign data_pins_out[i*BYTE_W +: BYTE_W] = rd_word[i*LANE_W +: BYTE_W];
			assign parity_pins_out[i]              = rd_word[i*LANE_W + BYTE_W];
			assign data_pins_oe[i*BYTE_W +: BYTE_W] = {BYTE_W{drive_pins}}; // RULE11
			assign parity_pins_oe[i]               = drive_pins;            // RULE12
		end
	endgenerate

endmodule

// ---- test/sram_pin_ctrl_assertions.sv ----
// Concurrent checks on the SRAM pin front end ports
`timescale 1ns/100ps
module sram_pin_checker #(
	parameter int LANES  = 4,
	parameter int BYTE_W = 8
) (
	// ==========
	// Clock and reset
	input wire logic                    core_clk,
	input wire logic                    sys_rst,
	// Controls
	input wire logic                    clock_qualify_n,
	input wire logic                    burst_step_or_load,
	input wire logic                    chip_sel_one_n,
	input wire logic                    chip_sel_two,
	input wire logic                    chip_sel_three_n,
	input wire logic                    write_strobe_n,
	input wire logic                    out_enable_n,
	// Data side
	input wire logic [LANES*BYTE_W-1:0] data_pins_out,
	input wire logic [LANES*BYTE_W-1:0] data_pins_oe,
	input wire logic [LANES-1:0]        parity_pins_oe
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	wire                          ld  = !clock_qualify_n && !burst_step_or_load;
	wire                          sel = !chip_sel_one_n && chip_sel_two && !chip_sel_three_n;
	wire [LANES*(BYTE_W+1)-1:0]   oe  = {parity_pins_oe, data_pins_oe};
	oe_high_off_a: assert property (out_enable_n |-> oe == '0)
		else $error("pins driven with output enable high");
	stall_out_hold_a: assert property (clock_qualify_n |=> $stable(data_pins_out))
		else $error("read data moved on an ignored edge");
	stall_oe_hold_a: assert property (clock_qualify_n ##1 $stable(out_enable_n) |-> $stable(oe))
		else $error("drive state moved on an ignored edge");
	deselect_quiet_a: assert property ((ld && !sel) ##1 !clock_qualify_n |=> oe == '0)
		else $error("deselected slot drives the pins");
	write_phase_quiet_a: assert property ((ld && sel && !write_strobe_n) ##1 !clock_qualify_n |=> oe == '0)
		else $error("pins driven in write data phase");
	read_drive_a: assert property ((ld && sel && write_strobe_n) ##1 !clock_qualify_n
		##1 !out_enable_n |-> oe == '1)
		else $error("read slot not driven");
	burst_drive_a: assert property ((ld && sel && write_strobe_n)
		##1 (!clock_qualify_n && burst_step_or_load) ##1 !clock_qualify_n ##1 !out_enable_n |-> oe == '1)
		else $error("burst read step not driven");
	lane_oe_even_a: assert property (oe == '0 || oe == '1)
		else $error("lanes disagree on drive");
endmodule

bind sram_pin_ctrl sram_pin_checker #(.LANES(LANES), .BYTE_W(BYTE_W)) u_chk (.core_clk(core_clk),
	.sys_rst(sys_rst), .clock_qualify_n(clock_qualify_n), .burst_step_or_load(burst_step_or_load),
	.chip_sel_one_n(chip_sel_one_n), .chip_sel_two(chip_sel_two), .chip_sel_three_n(chip_sel_three_n),
	.write_strobe_n(write_strobe_n), .out_enable_n(out_enable_n), .data_pins_out(data_pins_out),
	.data_pins_oe(data_pins_oe), .parity_pins_oe(parity_pins_oe));

// ---- test/host_sram_model.sv ----
// Host memory controller model driving the SRAM control pins
`timescale 1ns/100ps
module host_sram_model (
	// Clock
	input  wire logic                             core_clk,
	// Control pins
	output logic                                  clock_qualify_n,
	output logic [sram_pin_pkg::ADDR_W-1:0]       addr,
	output logic                                  burst_step_or_load,
	output logic                                  chip_sel_one_n,
	output logic                                  chip_sel_two,
	output logic                                  chip_sel_three_n,
	output logic                                  write_strobe_n,
	output logic [3:0]                            lane_sel_n,
	// Host side of data and parity
	output logic [31:0]                           host_data,
	output logic [3:0]                            host_par
);
	initial begin
		{clock_qualify_n, burst_step_or_load, write_strobe_n, lane_sel_n} = 7'h1f;
		{chip_sel_one_n, chip_sel_two, chip_sel_three_n, addr, host_par, host_data} = '0;
	end
	// ==========
	// One qualified cycle
	task step(input logic [2:0] sel, input logic we_n, input logic adv, input logic [18:0] a,
		input logic [3:0] ln, input logic drv, input logic [35:0] dp);
		@(posedge core_clk);
		clock_qualify_n <= 1'b0;
		{chip_sel_one_n, chip_sel_two, chip_sel_three_n} <= sel;
		write_strobe_n <= we_n;
		burst_step_or_load <= adv;
		addr <= a;
		lane_sel_n <= ln;
		// Released pins flip so a stale value never looks right
		{host_par, host_data} <= drv ? dp : ~{host_par, host_data};
	endtask
	task hold();
		@(posedge core_clk);
		clock_qualify_n <= 1'b1;
	endtask
endmodule

// ---- test/test_sync_burst_sram_pin_control.sv ----
// Self-checking bench for the burst SRAM pin front end
`timescale 1ns/100ps
module test_sync_burst_sram_pin_control;
	logic                          core_clk = 1'b0;
	logic                          sys_rst = 1'b1;
	logic                          oe_n = 1'b0;
	logic                          strap = 1'b1;
	logic                          cq_n, adv, s1_n, s2, s3_n, we_n;
	logic [sram_pin_pkg::ADDR_W-1:0] a;
	logic [3:0]                    ln, par_out, par_oe, hpar;
	logic [31:0]                   d_out, d_oe, hdat;
	logic [35:0]                   mem5;
	int                            failures = 0;
	int                            comparisons = 0;
	int                            cycles = 0;
	wire [31:0]                    d_wire = (d_oe & d_out) | (~d_oe & hdat);
	wire [3:0]                     p_wire = (par_oe & par_out) | (~par_oe & hpar);
	always #2.5 core_clk = ~core_clk;
	host_sram_model u_host (.core_clk(core_clk), .clock_qualify_n(cq_n), .addr(a), .burst_step_or_load(adv),
		.chip_sel_one_n(s1_n), .chip_sel_two(s2), .chip_sel_three_n(s3_n), .write_strobe_n(we_n),
		.lane_sel_n(ln), .host_data(hdat), .host_par(hpar));
	sram_pin_ctrl u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .clock_qualify_n(cq_n), .addr(a),
		.burst_step_or_load(adv), .burst_order_strap(strap), .chip_sel_one_n(s1_n), .chip_sel_two(s2),
		.chip_sel_three_n(s3_n), .write_strobe_n(we_n), .lane_a_write_sel_n(ln[0]), .lane_b_write_sel_n(ln[1]),
		.lane_c_write_sel_n(ln[2]), .lane_d_write_sel_n(ln[3]), .out_enable_n(oe_n), .data_pins_in(d_wire),
		.data_pins_out(d_out), .data_pins_oe(d_oe), .parity_pins_in(p_wire), .parity_pins_out(par_out),
		.parity_pins_oe(par_oe));
	// ==========
	// Shared tasks
	task check(input logic [35:0] seen, input logic [35:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task op(input logic [2:0] sel, input logic w, input logic st, input logic [18:0] ad, input logic [3:0] l);
		u_host.step(sel, w, st, ad, l, 1'b0, 36'h0);
	endtask
	task idle();
		op(3'b110, 1'b1, 1'b0, 19'h0, 4'hf);
	endtask
	task wr(input logic [18:0] ad, input logic [3:0] l, input logic [35:0] dp);
		op(3'b010, 1'b0, 1'b0, ad, l);
		idle();
		u_host.step(3'b110, 1'b1, 1'b0, 19'h0, 4'hf, 1'b1, dp);
	endtask
	task rd(input logic [18:0] ad, input logic [3:0] l, input logic [35:0] exp);
		op(3'b010, 1'b1, 1'b0, ad, l);
		idle();
		idle();
		#1;
		check({p_wire, d_wire}, exp);
	endtask
	// ==========
	// Scenarios
	task t_lanes();
		mem5 = 36'h9_11223344;
		wr(19'h5, 4'h0, mem5);
		wr(19'h6, 4'h0, 36'h6_aabbccdd);
		rd(19'h5, 4'hf, mem5);
		for (int i = 0; i < 4; i++) begin
			wr(19'h5, ~(4'h1 << i), {4'hf, {4{8'h5a + 8'(i)}}});
			mem5[8*i +: 8] = 8'h5a + 8'(i);
			mem5[32+i] = 1'b1;
			rd(19'h5, 4'hf, mem5);
		end
		rd(19'h5, 4'h0, mem5);
	endtask
	task t_turn();
		// Read right behind a write to the same word takes the forwarding path
		u_host.step(3'b010, 1'b0, 1'b0, 19'h7, 4'h0, 1'b0, 36'h0);
		u_host.step(3'b010, 1'b1, 1'b0, 19'h7, 4'hf, 1'b0, 36'h0);
		u_host.step(3'b110, 1'b1, 1'b0, 19'h0, 4'hf, 1'b1, 36'h3_0f1e2d3c);
		idle();
		#1;
		check({p_wire, d_wire}, 36'h3_0f1e2d3c);
	endtask
	task t_selects();
		for (int c = 0; c < 8; c++) begin
			op(3'(c), 1'b1, 1'b0, 19'h5, 4'hf);
			idle();
			idle();
			#1;
			check({par_oe, d_oe}, {36{c == 2}});
		end
	endtask
	task t_stall();
		op(3'b010, 1'b1, 1'b0, 19'h6, 4'hf);
		idle();
		u_host.hold();
		oe_n <= 1'b1;
		#1;
		check({par_oe, d_oe}, 36'h0);
		u_host.hold();
		oe_n <= 1'b0;
		#1;
		check({p_wire, d_wire}, 36'h6_aabbccdd);
		idle();
	endtask
	task t_burst();
		logic [35:0] exp [4];
		for (int i = 0; i < 4; i++) begin
			exp[i] = {4'(i + 1), {4{8'h80 + 8'(i)}}};
			wr(19'h8 + 19'(i), 4'h0, exp[i]);
		end
		op(3'b010, 1'b1, 1'b0, 19'h9, 4'hf);
		// Selects left inactive: a step must keep the loaded access
		for (int i = 0; i < 5; i++) begin
			if (i < 3) op(3'b110, 1'b1, 1'b1, 19'h0, 4'hf);
			else idle();
			#1;
			if (i > 0) check({p_wire, d_wire}, exp[(i - 1) ^ 1]);
		end
	endtask
	task t_linear();
		logic [35:0] w [4];
		// Strap changes only inside a second reset, as a static pin must
		@(posedge core_clk);
		sys_rst <= 1'b1;
		strap <= 1'b0;
		repeat (2) @(posedge core_clk);
		sys_rst <= 1'b0;
		// Burst write from 11 lands at 11, 12, 13, 10; data trails its command by two edges
		for (int i = 0; i < 6; i++) begin
			if (i < 4) w[i] = {4'(8 - i), {4{8'hc0 + 8'(i)}}};
			u_host.step((i < 4) ? 3'b010 : 3'b110, 1'b0, (i > 0 && i < 4), 19'h11, 4'h0, (i > 1), w[(i + 2) & 3]);
		end
		// Read starts at 12 so an order wrong both ways cannot cancel out
		u_host.step(3'b010, 1'b1, 1'b0, 19'h12, 4'hf, 1'b0, 36'h0);
		for (int i = 0; i < 5; i++) begin
			u_host.step(3'b110, 1'b1, i < 3, 19'h0, 4'hf, 1'b0, 36'h0);
			#1;
			if (i > 0) check({p_wire, d_wire}, w[i & 3]);
		end
	endtask
	// ==========
	// Run control
	task give_verdict();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// Ceiling well above the roughly 110 cycles the scenarios need
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			give_verdict();
		end
	end
	initial begin
		repeat (6) @(posedge core_clk);
		sys_rst <= 1'b0;
		t_lanes();
		t_turn();
		t_selects();
		t_stall();
		t_burst();
		t_linear();
		give_verdict();
	end
endmodule
